// *** logic/hae_monitor.sv ***
// Home agent event monitor: APB registers, tracker pool, event sources
// ---------------------------------------------------------------
// Overview of operation
// - Code 6c counts egress stalls awaiting stop credits, four mask bits.
// - Code 1b counts requests to regions 0-7, one-hot mask, two per cycle.
// - Code 1c counts requests to regions 8-11 via mask bits 0-3.
// - Each memory request is decoded to its region before counting.
// - Code 02 counts pool-full cycles, general or all; needs backup mode.
// - Entries allocate when free and release only after completion.
// - Code 03 counts pool non-empty cycles, local and/or remote.
// - Code 04 adds selected class occupancy each cycle, at most 128.
// - Code 05 adds pending-data transactions, local/remote, at most 127.
// - Codes 2a, 32, 36 count egress-full cycles per ring.
// - Egress-full mask picks scheduler bank 0, bank 1 or either.
// - Code 0e counts acknowledge ring sends, one per cycle.
// - Code 10 counts data responses by cache, core or remote socket.
// - Code 34 adds data egress fill, at most 20 per cycle.
// - Code 6d counts cycles of prolonged injection starvation.
// ---------------------------------------------------------------
`default_nettype none
module hae_monitor
    import hae_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Tracker pool
    input wire logic alloc_in,
    input wire logic [2:0] alloc_class_in,
    input wire logic rel_in,
    input wire logic [2:0] rel_class_in,
    input wire logic bt_mode_in,
    output logic pool_free_out,
    // Region requests
    input wire logic req_a_valid_in,
    input wire logic [3:0] req_a_region_in,
    input wire logic req_b_valid_in,
    input wire logic [3:0] req_b_region_in,
    // Egress and ring
    input wire logic [3:0] credit_stall_in,
    input wire logic [6:0] pend_loc_in,
    input wire logic [6:0] pend_rem_in,
    input wire logic [1:0] egf_ad_in,
    input wire logic [1:0] egf_ak_in,
    input wire logic [1:0] egf_bl_in,
    input wire logic ack_tx_in,
    input wire logic [2:0] drs_dest_in,
    input wire logic [4:0] data_fill_in,
    input wire logic egress_blocked_in
);
    logic acc;
    logic wr_fire;
    logic [1:0] idx;
    logic hit;
    logic [31:0] rd_c;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] ctl_q [NUM_CTR];
    logic [31:0] cnt [NUM_CTR];
    logic [7:0] occ_q [NUM_CLS];
    logic [47:0] occ_flat;
    logic [7:0] total_q;
    logic [7:0] total_d;
    logic alloc_ok;
    logic rel_ok;
    logic pool_free_q;
    logic ne_loc;
    logic ne_rem;
    logic full_gp;
    logic full_all;
    logic [11:0] reg_a_q;
    logic [11:0] reg_b_q;
    logic [15:0] starve_cnt_q;
    logic starved_q;

    // ---------------------------------------------------------------
    // APB slave
    // ---------------------------------------------------------------
    // One wait state so read data leaves a flip-flop
    assign acc = psel_in && penable_in;
    assign wr_fire = acc && pready_q && pwrite_in;
    assign idx = paddr_in[3:2];
    assign prdata_out = prdata_q;
    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;

    always_comb begin
        hit = 1'b0;
        rd_c = '0;
        if (paddr_in[1:0] == 2'b00) begin
            if (paddr_in[7:4] == A_CTL0[7:4]) begin
                hit = 1'b1;
                rd_c = ctl_q[idx];
            end else if (paddr_in[7:4] == A_CTR0[7:4]) begin
                hit = 1'b1;
                rd_c = cnt[idx];
            end else if (paddr_in == A_STAT) begin
                hit = 1'b1;
                rd_c = {22'h00_0000, pool_free_q, starved_q, total_q};
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= acc && !pready_q;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end else if (acc && !pready_q) begin
            prdata_q <= (hit && !pwrite_in) ? rd_c : 32'h0000_0000;
            pslverr_q <= !hit;
        end else begin
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Counter controls
    // ---------------------------------------------------------------
    // Only event, mask and enable bits hold state; others read zero
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < NUM_CTR; i++) begin
                ctl_q[i] <= CTL_RST;
            end
        end else if (wr_fire && paddr_in[1:0] == 2'b00 && paddr_in[7:4] == A_CTL0[7:4]) begin
            ctl_q[idx] <= pwdata_in & CTL_WMASK;
        end
    end

    // ---------------------------------------------------------------
    // Tracker pool
    // ---------------------------------------------------------------
    // Requests arriving with the pool full are not taken
    assign alloc_ok = alloc_in && alloc_class_in < 3'(NUM_CLS) && total_q < POOL_SIZE;
    assign rel_ok = rel_in && rel_class_in < 3'(NUM_CLS) && occ_q[rel_class_in] != 8'h00;
    assign total_d = total_q + 8'(alloc_ok) - 8'(rel_ok);

    generate
        for (genvar c = 0; c < NUM_CLS; c++) begin : g_cls
            always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    occ_q[c] <= '0;
                end else begin
                    occ_q[c] <= occ_q[c] + 8'(alloc_ok && alloc_class_in == 3'(c))
                        - 8'(rel_ok && rel_class_in == 3'(c));
                end
            end
            assign occ_flat[c * 8 +: 8] = occ_q[c];
        end
    endgenerate

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            total_q <= '0;
            pool_free_q <= 1'b1;
        end else begin
            total_q <= total_d;
            pool_free_q <= total_d < POOL_SIZE;
        end
    end
    assign pool_free_out = pool_free_q;

    // Even classes are local, odd classes remote
    assign ne_loc = |{occ_q[0], occ_q[2], occ_q[4]};
    assign ne_rem = |{occ_q[1], occ_q[3], occ_q[5]};
    assign full_all = total_q == POOL_SIZE;
    assign full_gp = total_q >= POOL_GP;

    // ---------------------------------------------------------------
    // Region decode
    // ---------------------------------------------------------------
    // Region numbers above the map never match any mask bit
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_a_q <= '0;
            reg_b_q <= '0;
        end else begin
            for (int r = 0; r < NUM_REGION; r++) begin
                reg_a_q[r] <= req_a_valid_in && req_a_region_in == 4'(r);
                reg_b_q[r] <= req_b_valid_in && req_b_region_in == 4'(r);
            end
        end
    end

    // ---------------------------------------------------------------
    // Injection starvation
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            starve_cnt_q <= '0;
            starved_q <= 1'b0;
        end else if (!egress_blocked_in) begin
            starve_cnt_q <= '0;
            starved_q <= 1'b0;
        end else if (starve_cnt_q < STARVE_CYCLES - 16'h0001) begin
            starve_cnt_q <= starve_cnt_q + 16'h0001;
        end else begin
            starved_q <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // Counters
    // ---------------------------------------------------------------
    // Exactly four counters, all able to take every event
    generate
        for (genvar i = 0; i < NUM_CTR; i++) begin : g_ctr
            hae_ctr_slice u_ctr (
                .clk_sys_in(clk_sys_in),
                .rst_n_in(rst_n_in),
                .ctl_in(ctl_q[i]),
                .load_in(wr_fire && paddr_in[1:0] == 2'b00
                    && paddr_in[7:4] == A_CTR0[7:4] && idx == 2'(i)),
                .load_val_in(pwdata_in),
                .stall_in(credit_stall_in),
                .reg_a_in(reg_a_q),
                .reg_b_in(reg_b_q),
                .full_gp_in(full_gp),
                .full_all_in(full_all),
                .bt_mode_in(bt_mode_in),
                .ne_loc_in(ne_loc),
                .ne_rem_in(ne_rem),
                .occ_in(occ_flat),
                .pend_loc_in(pend_loc_in),
                .pend_rem_in(pend_rem_in),
                .egf_ad_in(egf_ad_in),
                .egf_ak_in(egf_ak_in),
                .egf_bl_in(egf_bl_in),
                .ack_tx_in(ack_tx_in),
                .drs_in(drs_dest_in),
                .fill_in(data_fill_in),
                .starved_in(starved_q),
                .count_out(cnt[i])
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    AST_FULL_REFUSES: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        total_q == POOL_SIZE && !rel_in |=> total_q == POOL_SIZE)
        else $error("allocation taken with pool full");
    AST_NO_SPUR_REL: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !alloc_in && !rel_in |=> total_q == $past(total_q))
        else $error("occupancy moved with no alloc or release");
    AST_LOCAL_NE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        alloc_in && alloc_class_in == 3'h0 && total_q < POOL_SIZE |=> ne_loc)
        else $error("local allocation not seen as non-empty");
    AST_REGION_ONEHOT: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        req_a_valid_in && req_a_region_in == 4'h9 |=> reg_a_q == 12'h200)
        else $error("region decode wrong");
    AST_STARVE_LATE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !egress_blocked_in ##1 egress_blocked_in [*8] |-> !starved_q)
        else $error("starvation flagged too early");
    AST_STARVE_CLEAR: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !egress_blocked_in |=> !starved_q)
        else $error("starvation held after egress moved");
    AST_APB_WAIT: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        acc && !pready_q |=> pready_q ##1 !pready_q)
        else $error("APB answer not after one wait state");
    AST_CTL_WRITE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        wr_fire && paddr_in == A_CTL0 |=> ctl_q[0] == ($past(pwdata_in) & CTL_WMASK))
        else $error("control write not stored");
    COV_FULL: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        full_all);
    COV_STARVE: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        $rose(starved_q));
    COV_ERR: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        pready_q && pslverr_q);
endmodule // hae_monitor
`default_nettype wire

// *** pkg/hae_pkg.sv ***
// Constants for the home agent event monitor
`default_nettype none
package hae_pkg;
    // ---------------------------------------------------------------
    // Event codes
    // ---------------------------------------------------------------
    localparam logic [7:0] EV_STALL = 8'h6c;
    localparam logic [7:0] EV_REG_LO = 8'h1b;
    localparam logic [7:0] EV_REG_HI = 8'h1c;
    localparam logic [7:0] EV_FULL = 8'h02;
    localparam logic [7:0] EV_NE = 8'h03;
    localparam logic [7:0] EV_OCC = 8'h04;
    localparam logic [7:0] EV_PEND = 8'h05;
    localparam logic [7:0] EV_AD_FULL = 8'h2a;
    localparam logic [7:0] EV_AK_FULL = 8'h32;
    localparam logic [7:0] EV_BL_FULL = 8'h36;
    localparam logic [7:0] EV_AK_TX = 8'h0e;
    localparam logic [7:0] EV_BL_TX = 8'h10;
    localparam logic [7:0] EV_BL_FILL = 8'h34;
    localparam logic [7:0] EV_STARVE = 8'h6d;
    // ---------------------------------------------------------------
    // Per-cycle ceilings
    // ---------------------------------------------------------------
    localparam logic [7:0] MAX_REG = 8'h02;
    localparam logic [10:0] MAX_OCC = 11'h080;
    localparam logic [10:0] MAX_PEND = 11'h07f;
    localparam logic [4:0] MAX_FILL = 5'h14;
    // ---------------------------------------------------------------
    // Control word layout and register map
    // ---------------------------------------------------------------
    localparam int CTL_EV_LSB = 0;
    localparam int CTL_UM_LSB = 8;
    localparam int CTL_EN_BIT = 22;
    localparam logic [31:0] CTL_WMASK = 32'h0040_ffff;
    localparam logic [31:0] CTL_RST = 32'h0000_0000;
    localparam logic [7:0] A_CTL0 = 8'h00;
    localparam logic [7:0] A_CTR0 = 8'h10;
    localparam logic [7:0] A_STAT = 8'h20;
    // ---------------------------------------------------------------
    // Sizes
    // ---------------------------------------------------------------
    localparam int NUM_CTR = 4;
    localparam int NUM_CLS = 6;
    localparam int NUM_REGION = 12;
    localparam logic [7:0] POOL_SIZE = 8'h80;
    localparam logic [7:0] POOL_GP = 8'h70;
    localparam logic [15:0] STARVE_CYCLES = 16'h0040;
endpackage
`default_nettype wire

// *** logic/hae_ctr_slice.sv ***
// One event counter: event select, per-cycle increment, accumulation
`default_nettype none
module hae_ctr_slice
    import hae_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // Control and load
    input wire logic [31:0] ctl_in,
    input wire logic load_in,
    input wire logic [31:0] load_val_in,
    // Conditions
    input wire logic [3:0] stall_in,
    input wire logic [11:0] reg_a_in,
    input wire logic [11:0] reg_b_in,
    input wire logic full_gp_in,
    input wire logic full_all_in,
    input wire logic bt_mode_in,
    input wire logic ne_loc_in,
    input wire logic ne_rem_in,
    input wire logic [47:0] occ_in,
    input wire logic [6:0] pend_loc_in,
    input wire logic [6:0] pend_rem_in,
    input wire logic [1:0] egf_ad_in,
    input wire logic [1:0] egf_ak_in,
    input wire logic [1:0] egf_bl_in,
    input wire logic ack_tx_in,
    input wire logic [2:0] drs_in,
    input wire logic [4:0] fill_in,
    input wire logic starved_in,
    // Count
    output logic [31:0] count_out
);
    logic [7:0] ev;
    logic [7:0] um;
    logic [7:0] inc_d;
    logic [10:0] sum;
    logic [31:0] count_q;

    assign ev = ctl_in[CTL_EV_LSB +: 8];
    assign um = ctl_in[CTL_UM_LSB +: 8];
    assign count_out = count_q;

    // ---------------------------------------------------------------
    // Increment select
    // ---------------------------------------------------------------
    always_comb begin
        sum = '0;
        inc_d = '0;
        unique case (ev)
            EV_STALL: inc_d = 8'(|(stall_in & um[3:0]));
            EV_REG_LO: inc_d = 8'(|(reg_a_in[7:0] & um)) + 8'(|(reg_b_in[7:0] & um));
            EV_REG_HI: begin
                inc_d = 8'(|(reg_a_in[11:8] & um[3:0])) + 8'(|(reg_b_in[11:8] & um[3:0]));
            end
            // Without backup mode the fill level is meaningless, so count nothing
            EV_FULL: inc_d = 8'(bt_mode_in & ((um[0] & full_gp_in) | (um[1] & full_all_in)));
            EV_NE: inc_d = 8'((um[0] & ne_loc_in) | (um[1] & ne_rem_in));
            EV_OCC: begin
                for (int c = 0; c < NUM_CLS; c++) begin
                    if (um[2 + c]) begin
                        sum = sum + 11'(occ_in[c * 8 +: 8]);
                    end
                end
                inc_d = (sum > MAX_OCC) ? MAX_OCC[7:0] : sum[7:0];
            end
            EV_PEND: begin
                sum = (um[0] ? 11'(pend_loc_in) : 11'h000) + (um[1] ? 11'(pend_rem_in) : 11'h000);
                inc_d = (sum > MAX_PEND) ? MAX_PEND[7:0] : sum[7:0];
            end
            EV_AD_FULL: inc_d = 8'(|(egf_ad_in & um[1:0]));
            EV_AK_FULL: inc_d = 8'(|(egf_ak_in & um[1:0]));
            EV_BL_FULL: inc_d = 8'(|(egf_bl_in & um[1:0]));
            EV_AK_TX: inc_d = 8'(ack_tx_in);
            EV_BL_TX: inc_d = 8'(|(drs_in & um[2:0]));
            EV_BL_FILL: inc_d = 8'((fill_in > MAX_FILL) ? MAX_FILL : fill_in);
            EV_STARVE: inc_d = 8'(starved_in);
            default: inc_d = '0;
        endcase
    end

    // ---------------------------------------------------------------
    // Accumulator
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_q <= '0;
        end else if (load_in) begin
            count_q <= load_val_in;
        end else if (ctl_in[CTL_EN_BIT]) begin
            count_q <= count_q + 32'(inc_d);
        end
    end

    AST_COUNT_ADDS: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        ctl_in[CTL_EN_BIT] && !load_in |=> count_q == $past(count_q) + 32'($past(inc_d)))
        else $error("counter did not add its increment");
    AST_OCC_CEIL: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        ev == EV_OCC |-> inc_d <= 8'h80)
        else $error("occupancy increment above 128");
    AST_PEND_CEIL: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        ev == EV_PEND && um == 8'h03 && pend_loc_in == 7'h7f |-> inc_d == 8'h7f)
        else $error("pending increment not clipped at 127");
    AST_FILL_CEIL: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        ev == EV_BL_FILL |-> inc_d <= 8'h14)
        else $error("fill increment above 20");
    AST_REG_CEIL: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        ev == EV_REG_LO |-> inc_d <= MAX_REG)
        else $error("region increment above 2");
    AST_BT_OFF: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        ev == EV_FULL && !bt_mode_in |-> inc_d == 8'h00)
        else $error("full count without backup mode");
    AST_EGF_ANY: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        ev == EV_BL_FULL && um[1:0] == 2'b11 |-> inc_d == 8'(|egf_bl_in))
        else $error("egress full union wrong");
    COV_OCC: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        ev == EV_OCC && inc_d > 8'h01);
endmodule // hae_ctr_slice
`default_nettype wire

// *** test/hae_monitor_tb_top.sv ***
// Self-checking bench for the home agent event monitor
`default_nettype none
module hae_monitor_tb_top
    import hae_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------
    // Stimulus, observed outputs, bookkeeping
    // ------------------------------------------
    typedef struct packed {
        logic va; logic [3:0] ra; logic vb; logic [3:0] rb; logic [3:0] stall;
        logic [6:0] pl; logic [6:0] pr; logic [1:0] ead; logic [1:0] eak; logic [1:0] ebl;
        logic ack; logic [2:0] data_response_message; logic [4:0] fill;
    } hae_tb_ev_s;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic alloc = 1'b0, rel = 1'b0, bt = 1'b0, blk = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [2:0] acls = 3'h0, rcls = 3'h0;
    logic [31:0] prdata;
    logic pready, perr, pfree;
    hae_tb_ev_s ev = '0, nx = '0;
    int errors = 0, checked = 0, cyc = 0;
    // Undefined code 77 must add nothing
    logic [7:0] codes[11] = '{EV_STALL, EV_REG_LO, EV_REG_HI, EV_PEND, EV_AD_FULL,
        EV_AK_FULL, EV_BL_FULL, EV_AK_TX, EV_BL_TX, EV_BL_FILL, 8'h77};
    logic [31:0] tctl[4] = '{32'h0040_0203, 32'h0040_5404, 32'h0040_0202, 32'h0040_0102};

    hae_monitor hae_monitor_i (
        .clk_sys_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(perr), .alloc_in(alloc), .alloc_class_in(acls),
        .rel_in(rel), .rel_class_in(rcls), .bt_mode_in(bt), .pool_free_out(pfree),
        .req_a_valid_in(ev.va), .req_a_region_in(ev.ra), .req_b_valid_in(ev.vb),
        .req_b_region_in(ev.rb), .credit_stall_in(ev.stall), .pend_loc_in(ev.pl),
        .pend_rem_in(ev.pr), .egf_ad_in(ev.ead), .egf_ak_in(ev.eak), .egf_bl_in(ev.ebl),
        .ack_tx_in(ev.ack), .drs_dest_in(ev.data_response_message), .data_fill_in(ev.fill),
        .egress_blocked_in(blk));

    always #2.5 clk = ~clk;
    // ------------------------------------------
    // Reference model and bus tasks
    // ------------------------------------------
    function automatic int hit(logic v, logic [3:0] r, logic [7:0] m, int b);
        return int'(v && r >= b && r < b + ((b == 0) ? 8 : 4) && m[r - b]);
    endfunction
    // Per-cycle increment worked out from the next stimulus
    function automatic int inc(logic [7:0] c, logic [7:0] m);
        case (c)
            EV_STALL: return int'(|(nx.stall & m[3:0]));
            EV_REG_LO: return hit(nx.va, nx.ra, m, 0) + hit(nx.vb, nx.rb, m, 0);
            EV_REG_HI: return hit(nx.va, nx.ra, m, 8) + hit(nx.vb, nx.rb, m, 8);
            EV_PEND: return (m[0] ? nx.pl : 0) + (m[1] ? nx.pr : 0) > 127 ? 127 :
                (m[0] ? nx.pl : 0) + (m[1] ? nx.pr : 0);
            EV_AD_FULL: return int'(|(nx.ead & m[1:0]));
            EV_AK_FULL: return int'(|(nx.eak & m[1:0]));
            EV_BL_FULL: return int'(|(nx.ebl & m[1:0]));
            EV_AK_TX: return int'(nx.ack);
            EV_BL_TX: return int'(|(nx.data_response_message & m[2:0]));
            EV_BL_FILL: return (nx.fill > 20) ? 20 : int'(nx.fill);
            default: return 0;
        endcase
    endfunction
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] x);
        checked++;
        if (seen !== x) begin
            errors++;
            $display("BAD %s expected %h seen %h", s, x, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the hang guard ends a wait that never answers
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = perr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input string s, input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(s, r, x);
        chk("slverr", {31'h0, e}, {31'h0, xe});
    endtask
    // Random traffic for one event; the total is latency independent
    task automatic run_ev(input logic [7:0] c, input logic [7:0] m);
        int x;
        x = 0;
        wr(A_CTL0, {16'h0040, m, c});
        wr(A_CTR0, 32'h0000_0000);
        repeat (20) begin
            @(posedge clk);
            nx = 43'({$urandom(), $urandom()});
            x += inc(c, m);
            ev <= nx;
        end
        @(posedge clk);
        ev <= '0;
        repeat (3) @(posedge clk);
        rd("event", A_CTR0, 32'(x), 1'b0);
    endtask
    task automatic conclude();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Hang guard, far above the under two thousand cycles needed
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            conclude();
        end
    end
    // ------------------------------------------
    // Test sequence
    // ------------------------------------------
    initial begin
        logic [31:0] x[4];
        int cnt[6];
        int tot, run;
        void'($urandom(59));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd("ctl0", A_CTL0, CTL_RST, 1'b0);
        rd("status", A_STAT, 32'h0000_0200, 1'b0);
        wr(8'h04, 32'hffff_ffff);
        rd("ctl1", 8'h04, CTL_WMASK, 1'b0);
        wr(A_STAT, 32'hffff_ffff);
        rd("status", A_STAT, 32'h0000_0200, 1'b0);
        rd("unmapped", 8'h24, 32'h0000_0000, 1'b1);
        rd("misaligned", 8'h02, 32'h0000_0000, 1'b1);
        $display("done registers");
        for (int p = 0; p < 2; p++) begin
            foreach (codes[i]) run_ev(codes[i], (p == 0) ? 8'hff : 8'($urandom()));
        end
        $display("done events");
        for (int b = 1; b >= 0; b--) begin
            bt <= b[0];
            for (int k = 0; k < 4; k++) wr(8'(4 * k), tctl[k]);
            for (int k = 0; k < 4; k++) wr(A_CTR0 + 8'(4 * k), 32'h0000_0000);
            x = '{default: 0};
            cnt = '{default: 0};
            tot = 0;
            for (int i = 0; i < 350; i++) begin
                @(posedge clk);
                alloc <= (i < 180);
                acls <= 3'(i % 8);
                rel <= (i >= 190 && i < 340);
                rcls <= 3'(i % 6);
                if (i < 180 && tot < POOL_SIZE && i % 8 < 6) begin
                    cnt[i % 8]++;
                    tot++;
                end
                if (i >= 190 && i < 340 && cnt[i % 6] > 0) begin
                    cnt[i % 6]--;
                    tot--;
                end
                x[0] += (cnt[1] + cnt[3] + cnt[5] > 0);
                x[1] += cnt[0] + cnt[2] + cnt[4];
                x[2] += (b == 1 && tot == POOL_SIZE);
                x[3] += (b == 1 && tot >= POOL_GP);
                if (i == 185) chk("pool_free", {31'h0, pfree}, 32'h0000_0000);
            end
            for (int k = 0; k < 4; k++) rd("tracker", A_CTR0 + 8'(4 * k), x[k], 1'b0);
            $display("done tracker");
        end
        wr(A_CTL0, 32'h0040_006d);
        wr(A_CTR0, 32'h0000_0000);
        run = 0;
        tot = 0;
        for (int i = 0; i < 180; i++) begin
            @(posedge clk);
            blk <= (i != 63 && i < 164);
            // Flag outlives the run by one cycle, so judge on the previous run length
            tot += (run >= STARVE_CYCLES);
            run = (i != 63 && i < 164) ? run + 1 : 0;
        end
        rd("starved", A_CTR0, 32'(tot), 1'b0);
        $display("done starvation");
        conclude();
    end
endmodule // hae_monitor_tb_top
`default_nettype wire
